/* File: rtl/rdtc_top.sv */
// timing, clamp and serial configuration logic of the rgb digitizer
// ****************************************
// Overview of operation
// ****************************************
`timescale 1ns/100ps
module rdtc_top
  import rdtc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [1:0] serial_addr_pins_i,
  input wire logic hsync_i,
  input wire logic coast_i,
  input wire logic clamp_ext_i,
  input wire logic sample_clock_invert_pin_i,
  input wire logic external_pixel_clock_pin_i,
  input wire logic pll_clock_i,
  input wire logic power_down_n_i,
  input wire logic [23:0] adc_sample_i,
  output logic [23:0] port_a_o,
  output logic [23:0] port_b_o,
  output logic data_oe_o,
  output logic output_data_clock_o,
  output logic phase_aligned_sync_out_o,
  output logic clamp_o,
  output logic pll_power_down_o,
  output logic pll_sync_ref_o,
  output logic pll_coast_o,
  output logic [11:0] pll_divide_ratio_o,
  output logic [1:0] vco_band_o,
  output logic [2:0] pump_current_o,
  output logic [4:0] sample_phase_shift_o,
  output logic [23:0] channel_gain_o,
  output logic [17:0] channel_offset_o
);

  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int SYN_W = 35;
  logic [SYN_W-1:0] syn1_q;
  logic [SYN_W-1:0] syn2_q;
  logic scl_s, sda_s, hs_s, coast_s, clext_s, sample_clock_invert_pin_s, external_pixel_clock_pin_s, pllck_s, run_s;
  logic [1:0] apin_s;
  logic [23:0] adc_s;

  always_ff @(posedge ref_clk_i) begin
    syn1_q <= {scl_i, sda_i, hsync_i, coast_i, clamp_ext_i, sample_clock_invert_pin_i,
               external_pixel_clock_pin_i, pll_clock_i, power_down_n_i,
               serial_addr_pins_i, adc_sample_i};
    syn2_q <= syn1_q;
  end

  assign {scl_s, sda_s, hs_s, coast_s, clext_s, sample_clock_invert_pin_s, external_pixel_clock_pin_s, pllck_s, run_s,
          apin_s, adc_s} = syn2_q;

  // ****************************************
  // configuration registers
  // ****************************************
  logic [7:0] regs_q [NUM_REGS];
  logic [7:0] regs_d [NUM_REGS];
  logic wr_en;
  logic [3:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] ctl;

  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_d[i] = regs_q[i];
      if (wr_en && wr_idx == 4'(i)) begin
        regs_d[i] = wr_data & rdtc_used_bits(4'(i));
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_q[i] <= rst_i ? rdtc_reset_val(4'(i)) : regs_d[i];
    end
  end

  assign ctl = regs_q[REG_CONTROL];
  assign pll_divide_ratio_o = {regs_q[REG_DIV_HI], regs_q[REG_DIV_LO][7:4]};
  // top band bit is stored but the analog side decodes only two
  assign vco_band_o = regs_q[REG_VCO_PUMP][4:3];
  assign pump_current_o = regs_q[REG_VCO_PUMP][2:0];
  // driven out in both clock sources; the external clock path here is not shifted
  assign sample_phase_shift_o = regs_q[REG_PHASE][7:3];

  for (genvar c = 0; c < 3; c++) begin : g_chan
    assign channel_gain_o[8*c +: 8] = regs_q[REG_GAIN_R + 4'(c)];
    assign channel_offset_o[6*c +: 6] = regs_q[REG_OFFSET_R + 4'(c)][7:2];
  end

  // ****************************************
  // two-wire serial slave
  // ****************************************
  typedef enum logic [3:0] {
    SER_IDLE, SER_ADDR, SER_ADDR_ACK, SER_SUB, SER_SUB_ACK,
    SER_WR, SER_WR_ACK, SER_RD, SER_RD_ACK
  } rdtc_ser_e;

  rdtc_ser_e ser_q, ser_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] sub_q, sub_d;
  logic rw_q, rw_d;
  logic oe_q, oe_d;
  logic scl_p_q, sda_p_q;
  logic start, stop, scl_rise, scl_fall;
  logic [7:0] rd_val;

  assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign rd_val = (sub_q < NUM_REGS) ? regs_q[sub_q] : 8'h00;

  always_comb begin
    ser_d = ser_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    sub_d = sub_q;
    rw_d = rw_q;
    oe_d = oe_q;
    wr_en = 1'b0;
    wr_idx = sub_q;
    wr_data = sh_q;
    if (start) begin
      ser_d = SER_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop) begin
      ser_d = SER_IDLE;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      if (ser_q == SER_RD_ACK) begin
        // master nack ends the read burst
        if (sda_s) begin
          ser_d = SER_IDLE;
        end
      end else if (ser_q != SER_IDLE) begin
        cnt_d = cnt_q + 4'h1;
        sh_d = (ser_q == SER_RD) ? sh_q : {sh_q[6:0], sda_s};
      end
    end else if (scl_fall) begin
      case (ser_q)
        SER_ADDR: begin
          if (cnt_q == BYTE_BITS) begin
            // device address is strapped by the two address pins
            if (sh_q[7:1] == {SER_ADDR_TOP, apin_s}) begin
              ser_d = SER_ADDR_ACK;
              oe_d = 1'b1;
              rw_d = sh_q[0];
            end else begin
              ser_d = SER_IDLE;
            end
          end
        end
        SER_ADDR_ACK: begin
          cnt_d = 4'h0;
          if (rw_q) begin
            ser_d = SER_RD;
            sh_d = rd_val;
            oe_d = ~rd_val[7];
          end else begin
            ser_d = SER_SUB;
            oe_d = 1'b0;
          end
        end
        SER_SUB: begin
          if (cnt_q == BYTE_BITS) begin
            sub_d = sh_q[3:0];
            ser_d = SER_SUB_ACK;
            oe_d = 1'b1;
          end
        end
        SER_WR: begin
          if (cnt_q == BYTE_BITS) begin
            wr_en = 1'b1;
            sub_d = sub_q + 4'h1;
            ser_d = SER_WR_ACK;
            oe_d = 1'b1;
          end
        end
        SER_SUB_ACK, SER_WR_ACK: begin
          ser_d = SER_WR;
          cnt_d = 4'h0;
          oe_d = 1'b0;
        end
        SER_RD: begin
          if (cnt_q == BYTE_BITS) begin
            ser_d = SER_RD_ACK;
            sub_d = sub_q + 4'h1;
            oe_d = 1'b0;
          end else begin
            sh_d = {sh_q[6:0], 1'b0};
            oe_d = ~sh_q[6];
          end
        end
        SER_RD_ACK: begin
          ser_d = SER_RD;
          cnt_d = 4'h0;
          sh_d = rd_val;
          oe_d = ~rd_val[7];
        end
        default: begin
          ser_d = SER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ser_q <= SER_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      sub_q <= 4'h0;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      ser_q <= ser_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      sub_q <= sub_d;
      rw_q <= rw_d;
      oe_q <= oe_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // ****************************************
  // sample clock selection and edge finding
  // ****************************************
  logic ck_eff;
  logic ck_p_q;
  logic smp_ev, half_ev;

  // the pll clock is ignored while bypassed
  assign ck_eff = (ctl[CTL_BYPASS] ? external_pixel_clock_pin_s : pllck_s) ^ sample_clock_invert_pin_s;
  // active edge is the rise or the fall of the selected clock as the invert pin chooses
  assign smp_ev = ck_eff & ~ck_p_q;
  assign half_ev = ~ck_eff & ck_p_q;

  // ****************************************
  // data steering, data clock and sync pipeline
  // ****************************************
  logic hs_pol;
  logic hs_p_q, hs_p_d;
  logic ph_q, ph_d;
  logic [24:0] pipe_q [PIPE_DEPTH];
  logic [24:0] pipe_d [PIPE_DEPTH];
  logic [24:0] pout;
  logic [23:0] a_q, a_d, b_q, b_d, hold_q, hold_d;
  logic dck_q, dck_d;
  logic hso_q, hso_d;

  assign hs_pol = hs_s ^ ctl[CTL_SYNC_POL];
  assign pout = pipe_q[PIPE_DEPTH-1];

  always_comb begin
    hs_p_d = hs_p_q;
    ph_d = ph_q;
    pipe_d = pipe_q;
    a_d = a_q;
    b_d = b_q;
    hold_d = hold_q;
    dck_d = dck_q;
    hso_d = hso_q;
    if (smp_ev) begin
      hs_p_d = hs_pol;
      // sample at the sync leading edge is tagged for port a
      ph_d = (hs_pol & ~hs_p_q) ? 1'b0 : ~ph_q;
      pipe_d[0] = {ph_d, adc_s};
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe_d[i] = pipe_q[i-1];
      end
      // sync sampled on the same shifted clock, ahead of its data
      hso_d = hs_pol;
      if (!ctl[CTL_DUAL]) begin
        a_d = pout[23:0];
        b_d = 24'h000000;
        dck_d = 1'b0;
      end else if (!pout[24]) begin
        if (ctl[CTL_PARALLEL]) begin
          hold_d = pout[23:0];
          dck_d = 1'b1;
        end else begin
          a_d = pout[23:0];
          dck_d = 1'b0;
        end
      end else begin
        b_d = pout[23:0];
        if (ctl[CTL_PARALLEL]) begin
          a_d = hold_q;
          dck_d = 1'b0;
        end else begin
          dck_d = 1'b1;
        end
      end
    end else if (half_ev && !ctl[CTL_DUAL]) begin
      dck_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ck_p_q <= 1'b0;
      hs_p_q <= 1'b0;
      ph_q <= 1'b0;
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= 25'h0000000;
      end
      a_q <= 24'h000000;
      b_q <= 24'h000000;
      hold_q <= 24'h000000;
      dck_q <= 1'b0;
      hso_q <= 1'b0;
    end else begin
      ck_p_q <= ck_eff;
      hs_p_q <= hs_p_d;
      ph_q <= ph_d;
      pipe_q <= pipe_d;
      a_q <= a_d;
      b_q <= b_d;
      hold_q <= hold_d;
      dck_q <= dck_d;
      hso_q <= hso_d;
    end
  end

  // ****************************************
  // clamp generation
  // ****************************************
  typedef enum logic [1:0] {CL_IDLE, CL_WAIT, CL_ON} rdtc_clamp_e;

  rdtc_clamp_e cl_q, cl_d;
  logic [7:0] start_cnt_q, start_cnt_d;
  logic [7:0] len_cnt_q, len_cnt_d;
  logic clamp_q, clamp_d;
  logic ext_active;

  assign ext_active = clext_s ^ ctl[CTL_CLAMP_POL];

  always_comb begin
    cl_d = cl_q;
    start_cnt_d = start_cnt_q;
    len_cnt_d = len_cnt_q;
    // both counters step only on sample clock edges
    if (smp_ev) begin
      case (cl_q)
        CL_WAIT: begin
          if (start_cnt_q <= 8'h01) begin
            len_cnt_d = regs_q[REG_CLAMP_LEN];
            cl_d = (regs_q[REG_CLAMP_LEN] == 8'h00) ? CL_IDLE : CL_ON;
          end else begin
            start_cnt_d = start_cnt_q - 8'h01;
          end
        end
        CL_ON: begin
          len_cnt_d = len_cnt_q - 8'h01;
          if (len_cnt_q == 8'h01) begin
            cl_d = CL_IDLE;
          end
        end
        default: begin
          cl_d = CL_IDLE;
        end
      endcase
      // trailing edge of sync restarts the placement count
      if (~hs_pol & hs_p_q) begin
        start_cnt_d = regs_q[REG_CLAMP_START];
        cl_d = CL_WAIT;
      end
    end
    clamp_d = ctl[CTL_CLAMP_SRC] ? ext_active : (cl_d == CL_ON);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cl_q <= CL_IDLE;
      start_cnt_q <= 8'h00;
      len_cnt_q <= 8'h00;
      clamp_q <= 1'b0;
    end else begin
      cl_q <= cl_d;
      start_cnt_q <= start_cnt_d;
      len_cnt_q <= len_cnt_d;
      clamp_q <= clamp_d;
    end
  end

  // ****************************************
  // pll control and power down
  // ****************************************
  logic pd_q, ref_q, coast_q, doe_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pd_q <= 1'b0;
      ref_q <= 1'b0;
      coast_q <= 1'b0;
      doe_q <= 1'b0;
    end else begin
      pd_q <= ctl[CTL_BYPASS] | ~run_s;
      ref_q <= hs_pol;
      // pll holds its frequency while coasting
      coast_q <= coast_s ^ ctl[CTL_COAST_POL];
      doe_q <= run_s;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_q;
  assign port_a_o = a_q;
  assign port_b_o = b_q;
  assign data_oe_o = doe_q;
  assign output_data_clock_o = dck_q;
  assign phase_aligned_sync_out_o = hso_q;
  assign clamp_o = clamp_q;
  assign pll_power_down_o = pd_q;
  assign pll_sync_ref_o = ref_q;
  assign pll_coast_o = coast_q;

endmodule

/* File: rtl/rdtc_pkg.sv */
// constants and register map of the rgb digitizer timing control
package rdtc_pkg;
  // serial address is {SER_ADDR_TOP, a1, a0, rw}
  localparam logic [4:0] SER_ADDR_TOP = 5'h13;
  localparam logic [3:0] NUM_REGS = 4'hd;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] REG_DIV_HI = 4'h0;
  localparam logic [3:0] REG_DIV_LO = 4'h1;
  localparam logic [3:0] REG_VCO_PUMP = 4'h2;
  localparam logic [3:0] REG_PHASE = 4'h3;
  localparam logic [3:0] REG_CLAMP_START = 4'h4;
  localparam logic [3:0] REG_CLAMP_LEN = 4'h5;
  localparam logic [3:0] REG_GAIN_R = 4'h6;
  localparam logic [3:0] REG_OFFSET_R = 4'h9;
  localparam logic [3:0] REG_CONTROL = 4'hc;
  // control register bit positions
  localparam int CTL_DUAL = 7;
  localparam int CTL_PARALLEL = 6;
  localparam int CTL_SYNC_POL = 5;
  localparam int CTL_COAST_POL = 4;
  localparam int CTL_CLAMP_SRC = 3;
  localparam int CTL_CLAMP_POL = 2;
  localparam int CTL_BYPASS = 1;
  // sample sets between sync-aligned sample and port a
  localparam int PIPE_DEPTH = 4;

  function automatic logic [7:0] rdtc_reset_val(input logic [3:0] idx);
    case (idx)
      REG_DIV_HI: rdtc_reset_val = 8'h3f;
      REG_DIV_LO: rdtc_reset_val = 8'hf0;
      REG_VCO_PUMP: rdtc_reset_val = 8'h09;
      REG_PHASE: rdtc_reset_val = 8'h80;
      REG_CLAMP_START: rdtc_reset_val = 8'h80;
      REG_CLAMP_LEN: rdtc_reset_val = 8'h80;
      4'h6, 4'h7, 4'h8: rdtc_reset_val = 8'h80;
      4'h9, 4'ha, 4'hb: rdtc_reset_val = 8'h7c;
      REG_CONTROL: rdtc_reset_val = 8'hc4;
      default: rdtc_reset_val = 8'h00;
    endcase
  endfunction

  // implemented bits; the rest read as zero
  function automatic logic [7:0] rdtc_used_bits(input logic [3:0] idx);
    case (idx)
      REG_DIV_LO: rdtc_used_bits = 8'hf0;
      REG_VCO_PUMP: rdtc_used_bits = 8'h3f;
      REG_PHASE: rdtc_used_bits = 8'hf8;
      4'h9, 4'ha, 4'hb: rdtc_used_bits = 8'hfc;
      REG_CONTROL: rdtc_used_bits = 8'hfe;
      4'hd, 4'he, 4'hf: rdtc_used_bits = 8'h00;
      default: rdtc_used_bits = 8'hff;
    endcase
  endfunction
endpackage

/* File: verif/rdtc_top_sva.sv */
// assertion checker bound to the digitizer timing control top
`timescale 1ns/100ps
module rdtc_top_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic power_down_n_i,
  input wire logic [23:0] port_a_o,
  input wire logic data_oe_o,
  input wire logic output_data_clock_o,
  input wire logic phase_aligned_sync_out_o,
  input wire logic clamp_o,
  input wire logic pll_power_down_o,
  input wire logic [11:0] pll_divide_ratio_o,
  input wire logic [4:0] sample_phase_shift_o
);
  // ****
  // port properties
  // ****
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_dclk_data_quiet: assert property ($rose(output_data_clock_o) |-> $stable(port_a_o))
    else $error("port a moved at data clock rise");
  a_dclk_spacing: assert property ($rose(output_data_clock_o) |=> (!$rose(output_data_clock_o)) [*6])
    else $error("data clock rose twice in one sample period");
  a_pd_oe_off: assert property ((!power_down_n_i) [*8] |-> !data_oe_o)
    else $error("outputs driven in power down");
  a_pd_oe_on: assert property (power_down_n_i [*8] |-> data_oe_o)
    else $error("outputs not driven while powered");
  a_pd_pll_off: assert property ((!power_down_n_i) [*8] |-> pll_power_down_o)
    else $error("pll not powered down");
  a_sda_open_drain: assert property (sda_oe_o |-> !sda_o)
    else $error("sda driven high");
  a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i) && !$past(scl_i, 2))
    else $error("sda moved while scl high");
  a_div_legal: assert property (pll_divide_ratio_o >= 12'd221)
    else $error("divisor below legal range");
  a_phase_serial: assert property ($changed(sample_phase_shift_o) |-> !scl_i && !$past(scl_i))
    else $error("phase changed outside a serial load");
  c_sync_out: cover property ($rose(phase_aligned_sync_out_o));
  c_clamp: cover property ($rose(clamp_o));
  c_ack: cover property ($rose(sda_oe_o));
endmodule

bind rdtc_top rdtc_top_sva u_sva (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .power_down_n_i(power_down_n_i), .port_a_o(port_a_o), .data_oe_o(data_oe_o),
  .output_data_clock_o(output_data_clock_o),
  .phase_aligned_sync_out_o(phase_aligned_sync_out_o), .clamp_o(clamp_o),
  .pll_power_down_o(pll_power_down_o), .pll_divide_ratio_o(pll_divide_ratio_o),
  .sample_phase_shift_o(sample_phase_shift_o)
);

/* File: verif/rdtc_pixel_sink.sv */
// downstream pixel latch model fed by the output ports
`timescale 1ns/100ps
module rdtc_pixel_sink (
  input wire logic ref_clk_i,
  input wire logic output_data_clock_o,
  input wire logic phase_aligned_sync_out_o,
  input wire logic [23:0] port_a_o,
  input wire logic [23:0] port_b_o
);
  logic [23:0] qa[$];
  logic [23:0] qb[$];
  int sync_idx = 0;
  logic clk_q = 1'b0;
  logic sync_q = 1'b0;
  always @(posedge ref_clk_i) begin
    // index of the first latch after sync, so the bench can count sets
    if (phase_aligned_sync_out_o && !sync_q) begin
      sync_idx = qa.size();
    end
    // latches only on the rise, never on level, like a real register
    if (output_data_clock_o && !clk_q) begin
      qa.push_back(port_a_o);
      qb.push_back(port_b_o);
    end
    clk_q <= output_data_clock_o;
    sync_q <= phase_aligned_sync_out_o;
  end
endmodule

/* File: verif/rdtc_top_tb_top.sv */
// self-checking bench of the digitizer timing control
`timescale 1ns/100ps
module rdtc_top_tb_top
  import rdtc_pkg::*;
;
  localparam int HALF = 125;
  localparam logic [1:0] PINS = 2'b10;
  localparam logic [23:0] STEP = 24'h010203;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic scl_i = 1'b1;
  logic sda_m = 1'b1;
  logic hsync_i = 1'b0;
  logic coast_i = 1'b0;
  logic clamp_ext_i = 1'b0;
  logic pll_clk = 1'b0;
  logic ext_clk = 1'b0;
  logic pdn = 1'b1;
  logic [23:0] adc = 24'h0;
  logic [2:0] pc = 3'h0;
  logic [7:0] wd [12];
  logic [23:0] s0;
  logic [7:0] d0, d1;
  logic a;
  int errors = 0;
  int checked = 0;
  int t, d;
  wire sda_o, sda_oe_o, data_oe_o, output_data_clock_o, phase_aligned_sync_out_o, clamp_o;
  wire pll_power_down_o, pll_sync_ref_o, pll_coast_o;
  wire [23:0] port_a_o, port_b_o, channel_gain_o;
  wire [11:0] pll_divide_ratio_o;
  wire [1:0] vco_band_o;
  wire [2:0] pump_current_o;
  wire [4:0] sample_phase_shift_o;
  wire [17:0] channel_offset_o;
  wire sda_line = sda_m & !sda_oe_o;

  rdtc_top dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .serial_addr_pins_i(PINS), .hsync_i(hsync_i), .coast_i(coast_i),
    .clamp_ext_i(clamp_ext_i), .sample_clock_invert_pin_i(1'b0),
    .external_pixel_clock_pin_i(ext_clk), .pll_clock_i(pll_clk), .power_down_n_i(pdn),
    .adc_sample_i(adc), .port_a_o(port_a_o), .port_b_o(port_b_o), .data_oe_o(data_oe_o),
    .output_data_clock_o(output_data_clock_o),
    .phase_aligned_sync_out_o(phase_aligned_sync_out_o), .clamp_o(clamp_o),
    .pll_power_down_o(pll_power_down_o), .pll_sync_ref_o(pll_sync_ref_o),
    .pll_coast_o(pll_coast_o), .pll_divide_ratio_o(pll_divide_ratio_o),
    .vco_band_o(vco_band_o), .pump_current_o(pump_current_o),
    .sample_phase_shift_o(sample_phase_shift_o), .channel_gain_o(channel_gain_o),
    .channel_offset_o(channel_offset_o)
  );
  rdtc_pixel_sink sink (
    .ref_clk_i(ref_clk_i), .output_data_clock_o(output_data_clock_o),
    .phase_aligned_sync_out_o(phase_aligned_sync_out_o), .port_a_o(port_a_o),
    .port_b_o(port_b_o)
  );

  always #5 ref_clk_i = ~ref_clk_i;
  // ****
  // 80 ns pixel clock, samples move on its fall
  // ****
  always @(posedge ref_clk_i) begin
    pc <= pc + 3'h1;
    pll_clk <= pc[2];
    // in phase with the pll clock so a bypass switch makes no false edge
    ext_clk <= pc[2];
    if (pc == 3'h0) begin
      adc <= adc + STEP;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string nm);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s exp=%h seen=%h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic sbit(input logic b);
    sda_m <= b;
    cyc(HALF / 2);
    scl_i <= 1'b1;
    cyc(HALF);
    scl_i <= 1'b0;
    cyc(HALF / 2);
  endtask
  task automatic rbit(output logic b);
    sda_m <= 1'b1;
    cyc(HALF / 2);
    scl_i <= 1'b1;
    cyc(HALF / 2);
    b = sda_line;
    cyc(HALF / 2);
    scl_i <= 1'b0;
    cyc(HALF / 2);
  endtask
  task automatic start();
    sda_m <= 1'b1;
    cyc(HALF / 2);
    scl_i <= 1'b1;
    cyc(HALF / 2);
    sda_m <= 1'b0;
    cyc(HALF / 2);
    scl_i <= 1'b0;
    cyc(HALF / 2);
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    cyc(HALF / 2);
    scl_i <= 1'b1;
    cyc(HALF / 2);
    sda_m <= 1'b1;
    cyc(HALF);
  endtask
  task automatic tx(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) sbit(v[i]);
    rbit(b);
    ack = !b;
  endtask
  task automatic rx(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) rbit(v[i]);
    sbit(last);
  endtask
  task automatic wr(input logic [3:0] sub, input int n);
    logic k;
    start();
    tx({5'b10011, PINS, 1'b0}, k);
    chk(24'(k), 24'h1, "addr ack");
    tx({4'h0, sub}, k);
    for (int i = 0; i < n; i++) tx(wd[i], k);
    stop();
    cyc(8);
  endtask
  task automatic ctl(input logic [7:0] v);
    wd[0] = v;
    wr(REG_CONTROL, 1);
  endtask
  // hsync pulse aligned to a sample fall; measures the internal clamp after it
  task automatic line(output logic [23:0] lead);
    while (pc != 3'h0) cyc(1);
    hsync_i <= 1'b1;
    lead = adc + STEP;
    cyc(120);
    while (pc != 3'h0) cyc(1);
    hsync_i <= 1'b0;
    t = 0;
    while (!clamp_o && t < 400) begin
      cyc(1);
      t++;
    end
    d = 0;
    while (clamp_o && d < 400) begin
      cyc(1);
      d++;
    end
  endtask

  initial begin
    // serial traffic at 400 khz takes about 75k cycles
    cyc(95000);
    errors++;
    finish_test();
  end

  initial begin
    cyc(6);
    rst_i <= 1'b0;
    cyc(4);
    chk(24'(pll_divide_ratio_o), 24'd1023, "div rst");
    chk(24'(vco_band_o), 24'h1, "vco rst");
    chk(24'(pump_current_o), 24'h1, "pump rst");
    chk(24'(sample_phase_shift_o), 24'h10, "phase rst");
    chk(channel_gain_o, 24'h808080, "gain rst");
    chk(24'(channel_offset_o), 24'h1f7df, "offset rst");
    start();
    tx({5'b10011, PINS, 1'b0}, a);
    tx({4'h0, REG_CONTROL}, a);
    start();
    tx({5'b10011, PINS, 1'b1}, a);
    rx(1'b0, d0);
    rx(1'b1, d1);
    stop();
    chk(24'(d0), 24'hc4, "ctl rst");
    chk(24'(d1), 24'h0, "unmapped");
    start();
    tx({5'b10011, ~PINS, 1'b0}, a);
    chk(24'(a), 24'h0, "foreign ack");
    stop();
    wd = '{8'h0d, 8'hd0, 8'h3f, 8'hf8, 8'h03, 8'h02, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
    wr(REG_DIV_HI, 12);
    chk(24'(pll_divide_ratio_o), 24'd221, "div");
    chk(24'(vco_band_o), 24'h3, "vco");
    chk(24'(pump_current_o), 24'h7, "pump");
    chk(24'(sample_phase_shift_o), 24'h1f, "phase");
    chk(channel_gain_o, 24'hffffff, "gain");
    chk(24'(channel_offset_o), 24'h0, "offset");
    ctl(8'h04);
    line(s0);
    chk(sink.qa[sink.sync_idx + 4], s0, "single lead");
    chk(sink.qa[sink.sync_idx + 5], s0 + STEP, "single next");
    chk(port_b_o, 24'h0, "single b");
    chk(24'((t - 4) / 8), 24'h3, "clamp start");
    chk(24'(d), 24'd16, "clamp len");
    ctl(8'h84);
    line(s0);
    chk(sink.qa[sink.sync_idx + 2], s0, "dual lead");
    chk(sink.qb[sink.sync_idx + 2], s0 + STEP, "dual b");
    chk(sink.qa[sink.sync_idx + 3], s0 + 2 * STEP, "dual a2");
    clamp_ext_i <= 1'b1;
    ctl(8'h3e);
    chk(24'(pll_sync_ref_o), 24'h1, "sync inv");
    chk(24'(pll_coast_o), 24'h1, "coast inv");
    chk(24'(pll_power_down_o), 24'h1, "bypass");
    chk(24'(clamp_o), 24'h0, "ext clamp low");
    clamp_ext_i <= 1'b0;
    cyc(8);
    chk(24'(clamp_o), 24'h1, "ext clamp act");
    clamp_ext_i <= 1'b1;
    ctl(8'h08);
    chk(24'(pll_sync_ref_o), 24'h0, "sync");
    chk(24'(pll_coast_o), 24'h0, "coast");
    chk(24'(pll_power_down_o), 24'h0, "pll on");
    chk(24'(clamp_o), 24'h1, "ext clamp high");
    pdn <= 1'b0;
    cyc(8);
    chk(24'(data_oe_o), 24'h0, "pd oe");
    chk(24'(pll_power_down_o), 24'h1, "pd pll");
    pdn <= 1'b1;
    cyc(8);
    chk(24'(data_oe_o), 24'h1, "oe back");
    finish_test();
  end
endmodule
